/* include/agc_map.vh */
/*
  Register map of the ADC gain and filter control bank: offsets, field
  positions, reset values and writable masks.
  Assumes inclusion by bare name from design files.
*/
`ifndef AGC_MAP_VH
`define AGC_MAP_VH

`define AGC_ADDR_W 8
`define AGC_DATA_W 16

// Register addresses on the control port
`define AGC_OFS_DIG_GAIN 8'h20
`define AGC_OFS_AMP_GAIN 8'h21
`define AGC_OFS_FILT_CTRL 8'h22

// Digital gain fields
`define AGC_LDG_HI 15
`define AGC_LDG_LO 8
`define AGC_RDG_HI 7
`define AGC_RDG_LO 0

// Amplifier gain fields
`define AGC_MUTE_BIT 15
`define AGC_LAMP_HI 11
`define AGC_LAMP_LO 8
`define AGC_RAMP_HI 3
`define AGC_RAMP_LO 0

// Filter control fields
`define AGC_POL_BIT 12
`define AGC_DCBYP_BIT 1
`define AGC_HPEN_BIT 0

// Writable bits; everything else is reserved
`define AGC_MASK_DIG_GAIN 16'hFFFF
`define AGC_MASK_AMP_GAIN 16'h8F0F
`define AGC_MASK_FILT_CTRL 16'h1003

// Reset values
`define AGC_RST_DIG_GAIN 16'h0000
`define AGC_RST_AMP_GAIN 16'h0000
`define AGC_RST_FILT_CTRL 16'h0003

// Gain code constants
`define AGC_DG_MINUS_INF 8'h80
`define AGC_DG_MAX 8'h30
`define AGC_AMP_MAX 4'h8
`define AGC_AMP_STEP_DB 5'h03

`endif

/* design/agc_amp_decode.v */
/*
  Decodes one input amplifier gain code into a gain in whole dB.
  Assumes codes above the ninth setting are not written by software.
*/
`timescale 1ns/1ps
`include "agc_map.vh"

module agc_amp_decode (
  input wire [3:0] code,
  output reg [4:0] gainDb,
  output reg valid
);

  // Linear 3 dB steps; out-of-range codes clamp to the top setting
  always @* begin
    valid = (code <= `AGC_AMP_MAX);
    if (valid) begin
      gainDb = {1'b0, code} * `AGC_AMP_STEP_DB;
    end else begin
      gainDb = {1'b0, `AGC_AMP_MAX} * `AGC_AMP_STEP_DB;
    end
  end

endmodule

/* design/agc_regs.v */
/*
  ADC decimator gain control registers: per-channel digital gain, mute,
  input amplifier gain, polarity invert, DC filter bypass, high-pass.
  A write lands in its register at the taking edge and reaches the
  decoded outputs one edge later; a read strobe loads the read data
  register at its own taking edge.
  Reserved bits are masked on the way in, so the read path needs no
  second mask to return them as zero.
  Assumes a synchronous control port (address, write strobe, data) on
  clk, driven by the codec's own serial control decoder, so the port
  needs no synchroniser; reset is synchronous and active low.
*/
`timescale 1ns/1ps
`include "agc_map.vh"

// Behaviour
// - Digital gain register bits 15..8 hold the left channel gain code.
// - Digital gain register bits 7..0 hold the right channel gain code.
// - Gain codes are signed 0.5 dB steps; 0x30 is +24 dB, max.
// - Code 0x81 is -63.5 dB; code 0x80 silences the channel.
// - Amplifier register bit 15 set mutes the ADC output.
// - Amplifier register bits 11..8 set left input amplifier gain.
// - Amplifier register bits 3..0 set right input amplifier gain.
// - Amplifier code 0 is 0 dB, plus 3 dB per step, 8 is 24 dB.
// - Filter register bit 12 set inverts the ADC input polarity.
// - Filter bit 1 set bypasses the DC filter; resets to one.
// - Filter bit 0 set enables the output high-pass; resets to one.
module agc_regs (
  input wire clk,
  input wire rstn,
  input wire [7:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [15:0] regWdata,
  output reg [15:0] regRdata_q,
  output reg [7:0] leftDigitalGain_q,
  output reg [7:0] rightDigitalGain_q,
  output reg leftSilence_q,
  output reg rightSilence_q,
  output reg leftGainClamped_q,
  output reg rightGainClamped_q,
  output reg adcMute_q,
  output reg [3:0] leftInputAmpGain_q,
  output reg [3:0] rightInputAmpGain_q,
  output reg [4:0] leftAmpGainDb_q,
  output reg [4:0] rightAmpGainDb_q,
  output reg ampCodeError_q,
  output reg adcPolarityInvert_q,
  output reg dcFilterBypass_q,
  output reg highpassEnable_q
);

  // Stored register words; reserved bits always zero
  reg [15:0] digGain_q;
  reg [15:0] ampGain_q;
  reg [15:0] filtCtrl_q;
  reg [15:0] rdata_d;
  // Per-channel decode results; index 1 left, index 0 right
  wire [9:0] ampDb;
  wire [1:0] ampValid;
  wire [1:0] silence;
  wire [1:0] clamped;
  // Write strobes, at most one high in any cycle
  wire wrDigGain;
  wire wrAmpGain;
  wire wrFiltCtrl;
  // Channel index of the decode loop
  genvar ch;

  // Bit distance from the right field to the left field of a pair
  localparam DG_STRIDE = `AGC_LDG_LO - `AGC_RDG_LO;
  localparam AMP_STRIDE = `AGC_LAMP_LO - `AGC_RAMP_LO;

  // Address decode, shared by the write and read paths
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // Positive code above +24 dB; kept as written, only flagged
  function overMax;
    input [7:0] code;
    reg positive;
    begin
      positive = !code[7];
      overMax = positive && (code > `AGC_DG_MAX);
    end
  endfunction

  // 0x80 is minus infinity, not -64 dB
  function isSilent;
    input [7:0] code;
    begin
      isSilent = (code == `AGC_DG_MINUS_INF);
    end
  endfunction

  // Decode the address once; unmapped addresses raise no strobe
  assign wrDigGain = regWrite && hit(regAddr, `AGC_OFS_DIG_GAIN);
  assign wrAmpGain = regWrite && hit(regAddr, `AGC_OFS_AMP_GAIN);
  assign wrFiltCtrl = regWrite && hit(regAddr, `AGC_OFS_FILT_CTRL);

  // Register writes; reserved bits masked so they never store
  always @(posedge clk) begin
    if (!rstn) begin
      // DC bypass and high-pass come out of reset set, the rest cleared
      digGain_q <= `AGC_RST_DIG_GAIN;
      ampGain_q <= `AGC_RST_AMP_GAIN;
      filtCtrl_q <= `AGC_RST_FILT_CTRL;
    end else begin
      // Whole words only; no byte lanes on this port
      if (wrDigGain) begin
        digGain_q <= regWdata & `AGC_MASK_DIG_GAIN;
      end
      if (wrAmpGain) begin
        ampGain_q <= regWdata & `AGC_MASK_AMP_GAIN;
      end
      if (wrFiltCtrl) begin
        filtCtrl_q <= regWdata & `AGC_MASK_FILT_CTRL;
      end
    end
  end

  // Read mux; unmapped addresses return zero
  // Same compare as the write strobes, so both agree on the map
  always @* begin
    rdata_d = 16'h0000;
    if (hit(regAddr, `AGC_OFS_DIG_GAIN)) begin
      rdata_d = digGain_q;
    end else if (hit(regAddr, `AGC_OFS_AMP_GAIN)) begin
      rdata_d = ampGain_q;
    end else if (hit(regAddr, `AGC_OFS_FILT_CTRL)) begin
      rdata_d = filtCtrl_q;
    end
  end

  // Both channels decode alike; one loop serves left and right
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : gChan
      wire [7:0] dgCode;
      // This channel's slice of the digital gain word
      assign dgCode = digGain_q[`AGC_RDG_LO + ch * DG_STRIDE +: 8];
      // Amplifier code to whole dB, out-of-range codes flagged
      agc_amp_decode uAmp (
        .code(ampGain_q[`AGC_RAMP_LO + ch * AMP_STRIDE +: 4]),
        .gainDb(ampDb[ch * 5 +: 5]),
        .valid(ampValid[ch])
      );
      assign silence[ch] = isSilent(dgCode);
      // Positive codes above +24 dB are kept but flagged
      assign clamped[ch] = overMax(dgCode);
    end
  endgenerate

  // Read data refreshed only on a read strobe, held otherwise
  // A read and a write in one cycle return the old word
  always @(posedge clk) begin
    if (!rstn) begin
      regRdata_q <= 16'h0000;
    end else if (regRead) begin
      regRdata_q <= rdata_d;
    end
  end

  // Digital gain outputs, one cycle behind the register
  always @(posedge clk) begin
    if (!rstn) begin
      leftDigitalGain_q <= 8'h00;
      rightDigitalGain_q <= 8'h00;
      leftSilence_q <= 1'b0;
      rightSilence_q <= 1'b0;
      leftGainClamped_q <= 1'b0;
      rightGainClamped_q <= 1'b0;
    end else begin
      // Left and right codes sit side by side in one word
      leftDigitalGain_q <= digGain_q[`AGC_LDG_HI:`AGC_LDG_LO];
      rightDigitalGain_q <= digGain_q[`AGC_RDG_HI:`AGC_RDG_LO];
      leftSilence_q <= silence[1];
      rightSilence_q <= silence[0];
      leftGainClamped_q <= clamped[1];
      rightGainClamped_q <= clamped[0];
    end
  end

  // Amplifier outputs; raw code and its dB value move together
  always @(posedge clk) begin
    if (!rstn) begin
      adcMute_q <= 1'b0;
      leftInputAmpGain_q <= 4'h0;
      rightInputAmpGain_q <= 4'h0;
      leftAmpGainDb_q <= 5'h00;
      rightAmpGainDb_q <= 5'h00;
      ampCodeError_q <= 1'b0;
    end else begin
      adcMute_q <= ampGain_q[`AGC_MUTE_BIT];
      leftInputAmpGain_q <= ampGain_q[`AGC_LAMP_HI:`AGC_LAMP_LO];
      rightInputAmpGain_q <= ampGain_q[`AGC_RAMP_HI:`AGC_RAMP_LO];
      leftAmpGainDb_q <= ampDb[9:5];
      rightAmpGainDb_q <= ampDb[4:0];
      // Undefined codes still reach the outputs; the flag shows them
      ampCodeError_q <= !(&ampValid);
    end
  end

  // Filter controls; bypass and high-pass both leave reset set
  always @(posedge clk) begin
    if (!rstn) begin
      adcPolarityInvert_q <= 1'b0;
      dcFilterBypass_q <= 1'b1;
      highpassEnable_q <= 1'b1;
    end else begin
      adcPolarityInvert_q <= filtCtrl_q[`AGC_POL_BIT];
      dcFilterBypass_q <= filtCtrl_q[`AGC_DCBYP_BIT];
      highpassEnable_q <= filtCtrl_q[`AGC_HPEN_BIT];
    end
  end

endmodule

/* testbench/agc_regs_props.sv */
/* Port checker for the ADC gain control bank.
   Assumes it is bound to agc_regs from the bench top file. */
`timescale 1ns/1ps
module agc_regs_props (
  input logic clk,
  input logic rstn,
  input logic [7:0] regAddr,
  input logic regWrite,
  input logic regRead,
  input logic [15:0] regWdata,
  input logic [15:0] regRdata_q,
  input logic [7:0] leftDigitalGain_q,
  input logic [7:0] rightDigitalGain_q,
  input logic leftSilence_q,
  input logic leftGainClamped_q,
  input logic adcMute_q,
  input logic [3:0] leftInputAmpGain_q,
  input logic [4:0] leftAmpGainDb_q,
  input logic adcPolarityInvert_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Decoded fields show a write two edges after it is taken
  a_left_gain: assert property (
    regWrite && regAddr == 8'h20 ##2 1 |->
    leftDigitalGain_q == $past(regWdata[15:8], 2)) else $error("left gain");
  a_right_gain: assert property (
    regWrite && regAddr == 8'h20 ##2 1 |->
    rightDigitalGain_q == $past(regWdata[7:0], 2)) else $error("right gain");
  a_mute_bit: assert property (
    regWrite && regAddr == 8'h21 ##2 1 |->
    adcMute_q == $past(regWdata[15], 2)) else $error("mute bit");
  a_polarity_bit: assert property (
    regWrite && regAddr == 8'h22 ##2 1 |->
    adcPolarityInvert_q == $past(regWdata[12], 2)) else $error("polarity");
  // Flags must track the stored code in the same cycle
  a_silence_code: assert property (
    leftSilence_q == (leftDigitalGain_q == 8'h80)) else $error("silence");
  a_gain_limit: assert property (
    leftGainClamped_q == (!leftDigitalGain_q[7] &&
    leftDigitalGain_q > 8'h30)) else $error("clamp flag");
  a_amp_db: assert property (
    leftInputAmpGain_q <= 4'h8 |->
    leftAmpGainDb_q == 5'(leftInputAmpGain_q * 3)) else $error("amp dB");
  a_unmapped_read: assert property (
    regRead && regAddr == 8'h23 |=> regRdata_q == 16'h0000)
    else $error("unmapped read");
endmodule

/* testbench/agc_regs_test.sv */
/* Self-checking bench for the ADC gain control bank.
   Assumes agc_regs and the register map header are compiled first. */
`timescale 1ns/1ps
`include "agc_map.vh"
module agc_regs_test;
  logic clk = 0, rstn = 0, regWrite = 0, regRead = 0;
  logic [7:0] regAddr = 8'h20, a;
  logic [15:0] regWdata = 16'h0000, d, m [0:2];
  // Boundary words: silence, top amp codes, all-ones filter, over max
  logic [63:0] boundWords = 64'h8081_F8F8_FFFF_3130;
  wire [15:0] rdq;
  wire [7:0] lg, rg;
  wire [3:0] la, ra;
  wire [4:0] ldb, rdb;
  wire ls, rs, lc, rc, mu, ce, pol, byp, hpe;
  integer mismatches = 0, check_count = 0, cyc = 0, seed = 45, i;
  agc_regs dut (.clk(clk), .rstn(rstn), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
    .regRdata_q(rdq), .leftDigitalGain_q(lg), .rightDigitalGain_q(rg),
    .leftSilence_q(ls), .rightSilence_q(rs), .leftGainClamped_q(lc),
    .rightGainClamped_q(rc), .adcMute_q(mu), .leftInputAmpGain_q(la),
    .rightInputAmpGain_q(ra), .leftAmpGainDb_q(ldb),
    .rightAmpGainDb_q(rdb), .ampCodeError_q(ce),
    .adcPolarityInvert_q(pol), .dcFilterBypass_q(byp),
    .highpassEnable_q(hpe));
  always #25 clk = ~clk;
  task final_report;
    if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input [15:0] g, input [15:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Model copy of the bank; reserved bits never stored
  task wr(input [7:0] ad, input [15:0] dt);
    @(posedge clk);
    regAddr <= ad; regWdata <= dt; regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    if (ad == 8'h20) m[0] = dt & `AGC_MASK_DIG_GAIN;
    if (ad == 8'h21) m[1] = dt & `AGC_MASK_AMP_GAIN;
    if (ad == 8'h22) m[2] = dt & `AGC_MASK_FILT_CTRL;
  endtask
  // Read data is settled after the taking edge
  task rd(input [7:0] ad);
    @(posedge clk);
    regAddr <= ad; regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    chk(rdq, (ad >= 8'h20 && ad <= 8'h22) ? m[ad - 8'h20]
      : 16'h0000);
  endtask
  task outs;
    chk({lg, rg}, m[0]);
    chk({mu, 3'h0, la, 4'h0, ra}, m[1]);
    chk({3'h0, pol, 10'h0, byp, hpe}, m[2]);
    chk({ls, rs, ce},
      {m[0][15:8] == 8'h80, m[0][7:0] == 8'h80, 1'b0});
    chk({lc, rc}, {!m[0][15] && m[0][15:8] > 8'h30,
      !m[0][7] && m[0][7:0] > 8'h30});
    chk({ldb, rdb}, {5'(m[1][11:8] * 3), 5'(m[1][3:0] * 3)});
  endtask
  // Hang guard, far above the roughly 180 cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      final_report;
    end
  end
  initial begin
    m[0] = `AGC_RST_DIG_GAIN; m[1] = `AGC_RST_AMP_GAIN;
    m[2] = `AGC_RST_FILT_CTRL;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    for (i = 0; i < 4; i++) rd(8'h20 + i);
    outs;
    // Boundary codes first, then legal random traffic
    for (i = 0; i < 40; i++) begin
      a = (i < 4) ? 8'h20 + i[1:0] % 3 : 8'h20 + ($random(seed) & 3);
      d = (i < 4) ? boundWords[63 - i * 16 -: 16] : 16'($random(seed));
      if (a == 8'h21) begin
        d[11:8] = d[11:8] % 9;
        d[3:0] = d[3:0] % 9;
      end
      wr(a, d);
      rd(a);
      outs;
    end
    final_report;
  end
endmodule
bind agc_regs agc_regs_props chk_i (.clk(clk), .rstn(rstn),
  .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
  .regWdata(regWdata), .regRdata_q(regRdata_q),
  .leftDigitalGain_q(leftDigitalGain_q),
  .rightDigitalGain_q(rightDigitalGain_q), .leftSilence_q(leftSilence_q),
  .leftGainClamped_q(leftGainClamped_q), .adcMute_q(adcMute_q),
  .leftInputAmpGain_q(leftInputAmpGain_q),
  .leftAmpGainDb_q(leftAmpGainDb_q),
  .adcPolarityInvert_q(adcPolarityInvert_q));
